// [inc/dbcd_defines.svh]
// register offsets, field positions, codes and sizes for the command decoder
`ifndef DBCD_DEFINES_SVH
`define DBCD_DEFINES_SVH
`define DBCD_OFF_CDB0 8'h00
`define DBCD_OFF_CDB1 8'h04
`define DBCD_OFF_CDB2 8'h08
`define DBCD_OFF_CTRL 8'h0c
`define DBCD_OFF_STAT 8'h10
`define DBCD_OFF_DCNT 8'h14
`define DBCD_OFF_PTAB 8'h20
`define DBCD_OFF_GTAB 8'h40
`define DBCD_TAB_SPAN 8'h20
`define DBCD_CTRL_GO 0
`define DBCD_STAT_BUSY 0
`define DBCD_STAT_DONE 1
`define DBCD_STAT_CHECK 2
`define DBCD_STAT_KEY_LO 4
`define DBCD_OPC_WRITE 8'h2a
`define DBCD_OPC_SEEK 8'h2b
`define DBCD_OPC_WRVFY 8'h2e
`define DBCD_OPC_VERIFY 8'h2f
`define DBCD_OPC_DEFECT 8'h37
`define DBCD_BYTCHK_BIT 1
`define DBCD_PLIST_BIT 4
`define DBCD_GLIST_BIT 3
`define DBCD_FMT_SECTOR 3'h5
`define DBCD_FMT_BYTEOFS 3'h4
`define DBCD_KEY_NONE 4'h0
`define DBCD_KEY_RECOVERED 4'h1
`define DBCD_KEY_ILLEGAL 4'h5
`define DBCD_HDR_BYTES 16'h0004
`define DBCD_DESC_SHIFT 3
`define DBCD_SECTOR_BYTES 32'h0000_0200
`define DBCD_TAB_DEPTH 4
`define DBCD_CNT_RESET 3'h0
`endif

// [inc/dbcd_pkg.sv]
// types shared by the command decoder and its bench
package dbcd_pkg;
  // kinds of medium operation handed to the media engine
  typedef enum logic [1:0] {
    DBCD_OP_WRITE,
    DBCD_OP_SEEK,
    DBCD_OP_VERIFY
  } dbcd_op_e;

  // one medium operation request
  typedef struct packed {
    dbcd_op_e kind;
    logic [31:0] lba;
    logic [15:0] count;
  } dbcd_op_s;

  // one recorded defect location
  typedef struct packed {
    logic [23:0] cyl;
    logic [7:0] head;
    logic [31:0] sector;
  } dbcd_defect_s;
endpackage : dbcd_pkg

// [design/dbcd_decoder.sv]
// ten-byte disk command decoder with wishbone registers and defect list stream
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`include "dbcd_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dbcd_decoder
  import dbcd_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output dbcd_op_s OP_CMD,
  output logic OP_START,
  input wire logic OP_DONE,
  output logic [7:0] DIN_DATA,
  output logic DIN_VALID,
  output logic DIN_LAST,
  input wire logic DIN_READY
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_OP, ST_WAIT, ST_LOAD, ST_STREAM, ST_FINISH
  } dbcd_state_e;

  dbcd_state_e state_reg;
  logic [7:0] cdb_reg [0:11];
  dbcd_defect_s ptab_reg [0:`DBCD_TAB_DEPTH-1];
  dbcd_defect_s gtab_reg [0:`DBCD_TAB_DEPTH-1];
  logic [2:0] pcnt_reg;
  logic [2:0] gcnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic done_reg;
  logic check_reg;
  logic [3:0] key_reg;
  logic [3:0] key_next;
  logic check_next;
  dbcd_op_s op_reg;
  logic vfy_pend_reg;
  logic p_reg;
  logic g_reg;
  logic [2:0] fmt_reg;
  logic fmt_bad_reg;
  logic [15:0] idx_reg;
  logic [15:0] limit_reg;
  logic [7:0] din_reg;
  logic [7:0] cur_byte;
  logic [15:0] list_len;
  logic [3:0] desc_n;
  logic wb_req;
  logic wb_wr;
  logic go_pulse;
  logic done_clr;
  logic [7:0] opcode;
  logic [31:0] cdb_lba;
  logic [15:0] cdb_len;
  logic bytchk;

  // bus write merges only the enabled byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // fields of the command block, most significant byte first
  assign opcode = cdb_reg[0];
  assign cdb_lba = {cdb_reg[2], cdb_reg[3], cdb_reg[4], cdb_reg[5]};
  assign cdb_len = {cdb_reg[7], cdb_reg[8]};
  assign bytchk = cdb_reg[1][`DBCD_BYTCHK_BIT];

  // request decode; a new request is taken only once the previous ack fell
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign wb_wr = wb_req & WB_WE_I;
  assign go_pulse = wb_wr & (WB_ADR_I == `DBCD_OFF_CTRL) & WB_SEL_I[0]
                    & WB_DAT_I[`DBCD_CTRL_GO];
  assign done_clr = wb_wr & (WB_ADR_I == `DBCD_OFF_STAT) & WB_SEL_I[0]
                    & WB_DAT_I[`DBCD_STAT_DONE];

  // one wait state for every access, unmapped reads give zero
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // command block bytes; writes are taken only while idle, so the running command stays intact
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < 12; i++) begin
        cdb_reg[i] <= 8'h00;
      end
    end else if (wb_wr && state_reg == ST_IDLE && WB_ADR_I <= `DBCD_OFF_CDB2) begin
      for (int l = 0; l < 4; l++) begin
        if (WB_SEL_I[l]) begin
          cdb_reg[{WB_ADR_I[3:2], 2'(l)}] <= WB_DAT_I[8*l +: 8];
        end
      end
    end
  end

  // defect tables and their fill counts
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pcnt_reg <= `DBCD_CNT_RESET;
      gcnt_reg <= `DBCD_CNT_RESET;
      for (int i = 0; i < `DBCD_TAB_DEPTH; i++) begin
        ptab_reg[i] <= '0;
        gtab_reg[i] <= '0;
      end
    end else if (wb_wr) begin
      if (WB_ADR_I == `DBCD_OFF_DCNT) begin
        if (WB_SEL_I[0]) pcnt_reg <= WB_DAT_I[2:0];
        if (WB_SEL_I[1]) gcnt_reg <= WB_DAT_I[10:8];
      end else if (WB_ADR_I >= `DBCD_OFF_PTAB && WB_ADR_I < `DBCD_OFF_GTAB) begin
        if (WB_ADR_I[2]) begin
          ptab_reg[WB_ADR_I[4:3]].sector <= merge(ptab_reg[WB_ADR_I[4:3]].sector,
                                                  WB_DAT_I, WB_SEL_I);
        end else begin
          {ptab_reg[WB_ADR_I[4:3]].cyl, ptab_reg[WB_ADR_I[4:3]].head} <=
            merge({ptab_reg[WB_ADR_I[4:3]].cyl, ptab_reg[WB_ADR_I[4:3]].head},
                  WB_DAT_I, WB_SEL_I);
        end
      end else if (WB_ADR_I >= `DBCD_OFF_GTAB
                   && WB_ADR_I < `DBCD_OFF_GTAB + `DBCD_TAB_SPAN) begin
        if (WB_ADR_I[2]) begin
          gtab_reg[WB_ADR_I[4:3]].sector <= merge(gtab_reg[WB_ADR_I[4:3]].sector,
                                                  WB_DAT_I, WB_SEL_I);
        end else begin
          {gtab_reg[WB_ADR_I[4:3]].cyl, gtab_reg[WB_ADR_I[4:3]].head} <=
            merge({gtab_reg[WB_ADR_I[4:3]].cyl, gtab_reg[WB_ADR_I[4:3]].head},
                  WB_DAT_I, WB_SEL_I);
        end
      end
    end
  end

  // read data latched with the ack
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      rdata_reg <= 32'h0000_0000;
      if (WB_ADR_I <= `DBCD_OFF_CDB2) begin
        for (int l = 0; l < 4; l++) begin
          rdata_reg[8*l +: 8] <= cdb_reg[{WB_ADR_I[3:2], 2'(l)}];
        end
      end else if (WB_ADR_I == `DBCD_OFF_STAT) begin
        rdata_reg[`DBCD_STAT_BUSY] <= (state_reg != ST_IDLE);
        rdata_reg[`DBCD_STAT_DONE] <= done_reg;
        rdata_reg[`DBCD_STAT_CHECK] <= check_reg;
        rdata_reg[`DBCD_STAT_KEY_LO +: 4] <= key_reg;
      end else if (WB_ADR_I == `DBCD_OFF_DCNT) begin
        rdata_reg[2:0] <= pcnt_reg;
        rdata_reg[10:8] <= gcnt_reg;
      end else if (WB_ADR_I >= `DBCD_OFF_PTAB && WB_ADR_I < `DBCD_OFF_GTAB) begin
        rdata_reg <= WB_ADR_I[2] ? ptab_reg[WB_ADR_I[4:3]].sector
                     : {ptab_reg[WB_ADR_I[4:3]].cyl, ptab_reg[WB_ADR_I[4:3]].head};
      end else if (WB_ADR_I >= `DBCD_OFF_GTAB
                   && WB_ADR_I < `DBCD_OFF_GTAB + `DBCD_TAB_SPAN) begin
        rdata_reg <= WB_ADR_I[2] ? gtab_reg[WB_ADR_I[4:3]].sector
                     : {gtab_reg[WB_ADR_I[4:3]].cyl, gtab_reg[WB_ADR_I[4:3]].head};
      end
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // outcome of the command block, judged in the decode cycle
  always_comb begin
    check_next = 1'b0;
    key_next = `DBCD_KEY_NONE;
    if ((opcode == `DBCD_OPC_WRVFY || opcode == `DBCD_OPC_VERIFY) && bytchk) begin
      check_next = 1'b1;
      key_next = `DBCD_KEY_ILLEGAL;
    end else if (opcode != `DBCD_OPC_WRITE && opcode != `DBCD_OPC_SEEK
                 && opcode != `DBCD_OPC_WRVFY && opcode != `DBCD_OPC_VERIFY
                 && opcode != `DBCD_OPC_DEFECT) begin
      check_next = 1'b1;
      key_next = `DBCD_KEY_ILLEGAL;
    end
  end

  // command sequencer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= ST_IDLE;
      op_reg <= '0;
      vfy_pend_reg <= 1'b0;
      check_reg <= 1'b0;
      key_reg <= `DBCD_KEY_NONE;
      p_reg <= 1'b0;
      g_reg <= 1'b0;
      fmt_reg <= `DBCD_FMT_SECTOR;
      fmt_bad_reg <= 1'b0;
      limit_reg <= 16'h0000;
      idx_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (go_pulse) state_reg <= ST_DECODE;
        end
        ST_DECODE: begin
          check_reg <= check_next;
          key_reg <= key_next;
          op_reg.lba <= cdb_lba;
          op_reg.count <= cdb_len;
          vfy_pend_reg <= (opcode == `DBCD_OPC_WRVFY);
          idx_reg <= 16'h0000;
          state_reg <= ST_FINISH;
          if (!check_next) begin
            unique case (opcode)
              `DBCD_OPC_WRITE, `DBCD_OPC_WRVFY: begin
                op_reg.kind <= DBCD_OP_WRITE;
                if (cdb_len != 16'h0000) state_reg <= ST_OP;
              end
              `DBCD_OPC_SEEK: begin
                op_reg.kind <= DBCD_OP_SEEK;
                op_reg.count <= 16'h0000;
                state_reg <= ST_OP;
              end
              `DBCD_OPC_VERIFY: begin
                op_reg.kind <= DBCD_OP_VERIFY;
                if (cdb_len != 16'h0000) state_reg <= ST_OP;
              end
              default: begin
                // defect list request, format falls back to sector form
                p_reg <= cdb_reg[2][`DBCD_PLIST_BIT];
                g_reg <= cdb_reg[2][`DBCD_GLIST_BIT];
                fmt_bad_reg <= cdb_reg[2][2:0] != `DBCD_FMT_SECTOR
                               && cdb_reg[2][2:0] != `DBCD_FMT_BYTEOFS;
                fmt_reg <= (cdb_reg[2][2:0] == `DBCD_FMT_BYTEOFS) ? `DBCD_FMT_BYTEOFS
                           : `DBCD_FMT_SECTOR;
                limit_reg <= cdb_len;
                state_reg <= ST_LOAD;
              end
            endcase
          end
        end
        ST_OP: state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (OP_DONE) begin
            if (vfy_pend_reg) begin
              // ecc read-back of the same blocks, never a byte compare
              op_reg.kind <= DBCD_OP_VERIFY;
              vfy_pend_reg <= 1'b0;
              state_reg <= ST_OP;
            end else begin
              state_reg <= ST_FINISH;
            end
          end
        end
        ST_LOAD: begin
          // allocation and list end both cut the stream, whichever is first
          if (idx_reg >= limit_reg || idx_reg >= `DBCD_HDR_BYTES + list_len) begin
            state_reg <= ST_FINISH;
            if (fmt_bad_reg) begin
              check_reg <= 1'b1;
              key_reg <= `DBCD_KEY_RECOVERED;
            end
          end else begin
            state_reg <= ST_STREAM;
          end
        end
        ST_STREAM: begin
          if (DIN_READY) begin
            idx_reg <= idx_reg + 16'h0001;
            state_reg <= ST_LOAD;
          end
        end
        ST_FINISH: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // done flag; completion wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_FINISH) begin
      done_reg <= 1'b1;
    end else if (done_clr) begin
      done_reg <= 1'b0;
    end
  end

  // list size: selected lists only, none when both selects are clear
  assign desc_n = (p_reg ? {1'b0, pcnt_reg} : 4'h0)
                  + (g_reg ? {1'b0, gcnt_reg} : 4'h0);
  assign list_len = {12'h000, desc_n} << `DBCD_DESC_SHIFT;

  // byte at the current stream position
  always_comb begin
    logic [15:0] off;
    logic [2:0] d;
    logic [2:0] b;
    dbcd_defect_s ent;
    logic [31:0] val;
    ent = '0;
    val = 32'h0000_0000;
    off = idx_reg - `DBCD_HDR_BYTES;
    d = off[5:3];
    b = off[2:0];
    if (p_reg && d < {1'b0, pcnt_reg[1:0]} + {pcnt_reg[2], 2'b00}) begin
      ent = ptab_reg[d[1:0]];
    end else begin
      ent = gtab_reg[2'(d - (p_reg ? pcnt_reg : 3'h0))];
    end
    if (fmt_reg == `DBCD_FMT_BYTEOFS) begin
      val = 32'(ent.sector * `DBCD_SECTOR_BYTES);
    end else begin
      val = ent.sector;
    end
    cur_byte = 8'h00;
    if (idx_reg < `DBCD_HDR_BYTES) begin
      unique case (idx_reg[1:0])
        2'h0: cur_byte = 8'h00;
        2'h1: cur_byte = {3'h0, p_reg, g_reg, fmt_reg};
        2'h2: cur_byte = list_len[15:8];
        default: cur_byte = list_len[7:0];
      endcase
    end else begin
      unique case (b)
        3'h0: cur_byte = ent.cyl[23:16];
        3'h1: cur_byte = ent.cyl[15:8];
        3'h2: cur_byte = ent.cyl[7:0];
        3'h3: cur_byte = ent.head;
        3'h4: cur_byte = val[31:24];
        3'h5: cur_byte = val[23:16];
        3'h6: cur_byte = val[15:8];
        default: cur_byte = val[7:0];
      endcase
    end
  end

  // stream byte held in a flop so it is stable while valid stands
  always_ff @(posedge CLK) begin
    if (SRST) begin
      din_reg <= 8'h00;
    end else if (state_reg == ST_LOAD) begin
      din_reg <= cur_byte;
    end
  end

  assign DIN_DATA = din_reg;
  assign DIN_VALID = (state_reg == ST_STREAM);
  assign DIN_LAST = DIN_VALID && (idx_reg + 16'h0001 == limit_reg
                    || idx_reg + 16'h0001 == `DBCD_HDR_BYTES + list_len);
  assign OP_START = (state_reg == ST_OP);
  assign OP_CMD = op_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence decode_s(logic [7:0] code);
    state_reg == ST_DECODE && opcode == code && !check_next && cdb_len != 16'h0000;
  endsequence

  sequence start_s(dbcd_op_e k);
    ##1 OP_START && OP_CMD.kind == k && OP_CMD.lba == $past(cdb_lba);
  endsequence

  write_start_a: assert property (decode_s(`DBCD_OPC_WRITE) |-> start_s(DBCD_OP_WRITE))
    else $error("write command did not start a write");
  seek_start_a: assert property (state_reg == ST_DECODE && opcode == `DBCD_OPC_SEEK
    |-> ##1 OP_START && OP_CMD.kind == DBCD_OP_SEEK && OP_CMD.count == 16'h0000)
    else $error("seek command did not start a seek");
  verify_start_a: assert property (decode_s(`DBCD_OPC_VERIFY) |-> start_s(DBCD_OP_VERIFY))
    else $error("verify command did not start a verify");
  zero_count_a: assert property (state_reg == ST_DECODE && cdb_len == 16'h0000
    && opcode != `DBCD_OPC_SEEK |-> ##1 !OP_START ##1 !OP_START)
    else $error("zero length command started an operation");
  wv_followup_a: assert property (state_reg == ST_WAIT && OP_DONE && vfy_pend_reg
    |-> ##1 OP_START && OP_CMD.kind == DBCD_OP_VERIFY)
    else $error("write and verify skipped its read-back");
  bytchk_check_a: assert property (state_reg == ST_DECODE && bytchk
    && (opcode == `DBCD_OPC_WRVFY || opcode == `DBCD_OPC_VERIFY)
    |-> ##1 state_reg == ST_FINISH && check_reg && key_reg == `DBCD_KEY_ILLEGAL
    ##1 done_reg)
    else $error("byte compare request not refused");
  stream_limit_a: assert property (DIN_VALID |-> idx_reg < limit_reg
    && idx_reg < `DBCD_HDR_BYTES + list_len)
    else $error("defect byte beyond allocation or list end");
  header_len_a: assert property (DIN_VALID && idx_reg == 16'h0003
    |-> DIN_DATA == list_len[7:0]
    && list_len == 16'(8 * ((p_reg ? pcnt_reg : 3'h0) + (g_reg ? gcnt_reg : 3'h0))))
    else $error("defect list length wrong");
  header_fmt_a: assert property (DIN_VALID && idx_reg == 16'h0001
    |-> DIN_DATA[2:0] inside {`DBCD_FMT_SECTOR, `DBCD_FMT_BYTEOFS}
    && DIN_DATA[4:3] == {p_reg, g_reg})
    else $error("defect header format or selects wrong");
  fmt_recover_a: assert property (state_reg == ST_LOAD && fmt_bad_reg
    && idx_reg >= limit_reg |-> ##1 check_reg && key_reg == `DBCD_KEY_RECOVERED)
    else $error("bad format not reported as recovered");

endmodule : dbcd_decoder
`default_nettype wire

// [sim/dbcd_far_model.sv]
// media engine and defect stream sink standing at the decoder's far side
`timescale 1ns/100ps
`default_nettype none

module dbcd_far_model
  import dbcd_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire dbcd_op_s OP_CMD,
  input wire logic OP_START,
  output logic OP_DONE = 1'b0,
  input wire logic [7:0] DIN_DATA,
  input wire logic DIN_VALID,
  input wire logic DIN_LAST,
  output logic DIN_READY = 1'b0,
  input wire logic [3:0] LAT,
  input wire logic STALL
);
  dbcd_op_s ops[$];
  logic [7:0] got[$];
  int last_at = 0;
  int wait_cnt = 0;

  // media engine: logs each request, finishes it LAT+1 cycles later
  always @(posedge CLK) begin
    if (SRST) begin
      OP_DONE <= 1'b0;
      wait_cnt <= 0;
    end else if (OP_START) begin
      ops.push_back(OP_CMD);
      OP_DONE <= 1'b0;
      wait_cnt <= LAT + 1;
    end else begin
      // one assignment per edge: done pulses as the count runs out
      OP_DONE <= (wait_cnt == 1);
      wait_cnt <= (wait_cnt > 0) ? wait_cnt - 1 : 0;
    end
  end

  // sink: takes a byte on valid and ready; stalls every other cycle when asked
  always @(posedge CLK) begin
    if (SRST) begin
      DIN_READY <= 1'b0;
    end else begin
      if (DIN_VALID && DIN_READY) begin
        got.push_back(DIN_DATA);
        if (DIN_LAST) last_at <= got.size();
      end
      DIN_READY <= STALL ? ~DIN_READY : 1'b1;
    end
  end
endmodule : dbcd_far_model

`default_nettype wire

// [sim/disk_block_command_decoder_test.sv]
// self-checking bench for the ten-byte command decoder
`include "dbcd_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module disk_block_command_decoder_test
  import dbcd_pkg::*;
;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack, op_start, op_done, din_valid, din_last, din_ready;
  logic stall = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [7:0] din_data;
  logic [31:0] rnd = 32'h0000_000a;
  int mismatches = 0;
  int n_checks = 0;
  dbcd_op_s op_cmd;
  dbcd_defect_s pd[4], gd[4];
  dbcd_op_s exp_ops[$];
  logic [7:0] exp_b[$];
  logic [7:0] opcs[5] = '{8'h2a, 8'h2b, 8'h2e, 8'h2f, 8'h3b};

  dbcd_decoder dbcd_decoder_inst (.CLK(CLK), .SRST(SRST), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat),
    .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack), .OP_CMD(op_cmd), .OP_START(op_start),
    .OP_DONE(op_done), .DIN_DATA(din_data), .DIN_VALID(din_valid), .DIN_LAST(din_last),
    .DIN_READY(din_ready));
  dbcd_far_model dbcd_far_model_inst (.CLK(CLK), .SRST(SRST), .OP_CMD(op_cmd),
    .OP_START(op_start), .OP_DONE(op_done), .DIN_DATA(din_data), .DIN_VALID(din_valid),
    .DIN_LAST(din_last), .DIN_READY(din_ready), .LAT(lat), .STALL(stall));

  // 10 MHz clock
  initial begin
    forever #50 CLK = ~CLK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // cdb image, byte n at bits 8n+7..8n; multi-byte fields msb first
  function automatic logic [79:0] mk(input logic [7:0] opc, input logic [7:0] b1,
                                     input logic [31:0] mid, input logic [15:0] len);
    return {8'h00, len[7:0], len[15:8], 8'h00, mid[7:0], mid[15:8], mid[23:16], mid[31:24],
            b1, opc};
  endfunction : mk

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n;
    @(posedge CLK);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      check(0, 1, "bus ack timeout");
      close_out();
    end
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb_xfer(1'b1, a, d, x);
  endtask : wr

  // load cdb, start, poll until done, then clear done
  task automatic run_cmd(input logic [79:0] cdb, output logic [31:0] st);
    int n;
    dbcd_far_model_inst.ops.delete();
    dbcd_far_model_inst.got.delete();
    dbcd_far_model_inst.last_at = 0;
    rnd = lfsr(rnd);
    lat <= rnd[3:0];
    stall <= rnd[4];
    wr(`DBCD_OFF_CDB0, cdb[31:0]);
    wr(`DBCD_OFF_CDB1, cdb[63:32]);
    wr(`DBCD_OFF_CDB2, {16'h0000, cdb[79:64]});
    wr(`DBCD_OFF_CTRL, 32'h0000_0001);
    n = 0;
    do begin
      wb_xfer(1'b0, `DBCD_OFF_STAT, 32'h0, st);
      n++;
    end while (st[`DBCD_STAT_DONE] !== 1'b1 && n < 300);
    if (n >= 300) begin
      check(0, 1, "command timeout");
      close_out();
    end
    wr(`DBCD_OFF_STAT, 32'h0000_0002);
  endtask : run_cmd

  // every field compared; a seek must hand over a zero count
  task automatic cmp_ops();
    dbcd_op_s g;
    check(dbcd_far_model_inst.ops.size(), exp_ops.size(), "operation count");
    foreach (exp_ops[i]) begin
      g = (i < dbcd_far_model_inst.ops.size()) ? dbcd_far_model_inst.ops[i] : '0;
      check(g, exp_ops[i], "operation");
    end
  endtask : cmp_ops

  task automatic put_def(input logic [7:0] a, output dbcd_defect_s d);
    rnd = lfsr(rnd);
    d.cyl = rnd[23:0];
    d.head = rnd[31:24];
    rnd = lfsr(rnd);
    d.sector = rnd;
    wr(a, {d.cyl, d.head});
    wr(a + 8'h04, d.sector);
  endtask : put_def

  // main sequence
  initial begin
    logic [31:0] st, lba, v;
    logic [15:0] cnt, alloc, len;
    logic [7:0] opc, b1;
    logic [2:0] fmt, fr;
    logic [1:0] pg;
    logic bad;
    int nd;
    dbcd_defect_s d;
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    wb_xfer(1'b0, `DBCD_OFF_STAT, 32'h0, st);
    check(st, 32'h0, "status after reset");
    wb_xfer(1'b0, 8'hfc, 32'h0, st);
    check(st, 32'h0, "unmapped read");
    // medium commands: normal, zero count, byte-compare refusal, unknown opcode
    foreach (opcs[j]) begin
      for (int k = 0; k < 3; k++) begin
        opc = opcs[j];
        if (k == 2 && opc inside {`DBCD_OPC_WRITE, `DBCD_OPC_SEEK}) continue;
        rnd = lfsr(rnd);
        lba = rnd;
        cnt = (k == 1 || opc == `DBCD_OPC_SEEK) ? 16'h0 : (rnd[15:0] | 16'h0001);
        b1 = (k == 2) ? 8'h02 : 8'h00; // byte compare only in refusal cases
        bad = (k == 2) || (opc == 8'h3b);
        exp_ops.delete();
        if (!bad && (cnt != 16'h0 || opc == `DBCD_OPC_SEEK)) begin
          if (opc inside {`DBCD_OPC_WRITE, `DBCD_OPC_WRVFY})
            exp_ops.push_back(dbcd_op_s'{DBCD_OP_WRITE, lba, cnt});
          if (opc == `DBCD_OPC_SEEK) exp_ops.push_back(dbcd_op_s'{DBCD_OP_SEEK, lba, 16'h0});
          if (opc inside {`DBCD_OPC_WRVFY, `DBCD_OPC_VERIFY})
            exp_ops.push_back(dbcd_op_s'{DBCD_OP_VERIFY, lba, cnt});
        end
        run_cmd(mk(opc, b1, lba, cnt), st);
        cmp_ops();
        check(st[7:0], bad ? 8'h56 : 8'h02, "status");
      end
    end
    // defect tables: three factory entries, two field entries
    for (int i = 0; i < 4; i++) begin
      put_def(8'(`DBCD_OFF_PTAB + 8 * i), pd[i]);
      put_def(8'(`DBCD_OFF_GTAB + 8 * i), gd[i]);
    end
    wr(`DBCD_OFF_DCNT, 32'h0000_0203);
    wb_xfer(1'b0, `DBCD_OFF_DCNT, 32'h0, st);
    check(st, 32'h0000_0203, "defect counts readback");
    wb_xfer(1'b0, `DBCD_OFF_PTAB, 32'h0, st);
    check(st, {pd[0].cyl, pd[0].head}, "defect table readback");
    // every list selection, both formats, bad formats, short allocations
    for (int c = 0; c < 15; c++) begin
      pg = c[1:0];
      fmt = (c < 4 || c == 12) ? 3'h5 : (c < 8) ? 3'h4 : c[2:0];
      alloc = (c == 12) ? 16'h0 : (c == 13) ? 16'h000a : (c == 14) ? 16'h0003 : 16'h00ff;
      fr = (fmt == `DBCD_FMT_BYTEOFS) ? fmt : `DBCD_FMT_SECTOR;
      nd = (pg[1] ? 3 : 0) + (pg[0] ? 2 : 0);
      len = 16'(8 * nd);
      exp_b = '{8'h00, {3'h0, pg, fr}, len[15:8], len[7:0]};
      for (int i = 0; i < nd; i++) begin
        d = (pg[1] && i < 3) ? pd[i] : gd[pg[1] ? i - 3 : i];
        v = (fr == `DBCD_FMT_BYTEOFS) ? d.sector * `DBCD_SECTOR_BYTES : d.sector;
        exp_b = {exp_b, d.cyl[23:16], d.cyl[15:8], d.cyl[7:0], d.head,
                 v[31:24], v[23:16], v[15:8], v[7:0]};
      end
      while (exp_b.size() > alloc) void'(exp_b.pop_back());
      run_cmd(mk(`DBCD_OPC_DEFECT, 8'h00, {3'h0, pg, fmt, 24'h0}, alloc), st);
      check(dbcd_far_model_inst.got.size(), exp_b.size(), "stream length");
      foreach (exp_b[i]) begin
        if (i < dbcd_far_model_inst.got.size())
          check(dbcd_far_model_inst.got[i], exp_b[i], "defect byte");
      end
      if (exp_b.size() > 0) check(dbcd_far_model_inst.last_at, exp_b.size(), "last");
      check(st[7:0], (fr == fmt) ? 8'h02 : 8'h16, "defect status");
    end
    close_out();
  end
endmodule : disk_block_command_decoder_test

`default_nettype wire
